// *** hw/srpd_map.svh ***
/*
 Command codes, key bytes, configuration values and timing counts for the
 SPI register-access and power-down command interpreter.
 Assumes a 100 MHz system clock on both ends of the link.
*/
`ifndef SRPD_MAP_SVH
`define SRPD_MAP_SVH

`define SRPD_CMD_REG_WR 8'h20
`define SRPD_CMD_REG_RD 8'h21
`define SRPD_CMD_PWR_DN 8'h30
`define SRPD_CMD_SPI_CFG 8'h60
`define SRPD_KEY_FIRST 8'h5a
`define SRPD_KEY_SECOND 8'ha5
`define SRPD_CFG_LSB_FIRST 8'h42
`define SRPD_CFG_MSB_FIRST 8'h81
`define SRPD_LAST_BIT 3'h7

`define SRPD_CLK_NS 10
`define SRPD_SPI_CYC_NS 500
`define SRPD_LEAD_NS 4000
`define SRPD_LAG_NS 4000
`define SRPD_WAKE_NS 1000
`define SRPD_HALF_CYC ((`SRPD_SPI_CYC_NS / 2 + `SRPD_CLK_NS - 1) / `SRPD_CLK_NS)
`define SRPD_LEAD_CYC ((`SRPD_LEAD_NS + `SRPD_CLK_NS - 1) / `SRPD_CLK_NS)
`define SRPD_LAG_CYC ((`SRPD_LAG_NS + `SRPD_CLK_NS - 1) / `SRPD_CLK_NS)
`define SRPD_WAKE_CYC ((`SRPD_WAKE_NS + `SRPD_CLK_NS - 1) / `SRPD_CLK_NS)

`endif

// *** hw/srpd_pkg.sv ***
/*
 Types shared by both ends of the SPI register and power-down link.
 Assumes the constants of srpd_map.svh are included where needed.
*/
package srpd_pkg;
	typedef enum logic [3:0] {
		ds_cmd, ds_wr_addr, ds_wr_data, ds_rd_addr, ds_rd_dummy,
		ds_pd_key1, ds_pd_key2, ds_cfg, ds_ignore
	} srpd_dev_state_t;

	typedef enum logic [2:0] {
		op_write, op_read, op_power_down, op_config, op_wake
	} srpd_op_t;

	typedef enum logic [2:0] {
		hs_idle, hs_lead, hs_low, hs_high, hs_lag, hs_gap, hs_wake
	} srpd_host_state_t;
endpackage

// *** hw/srpd_if.sv ***
/*
 Pin-level link between the SPI master and the command interpreter.
 Resolves the shared wake pin and the MISO line from the drive enables;
 an undriven line reads high, as with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
interface srpd_if;
	logic sclk;
	logic mosi;
	logic cs_n;
	logic miso;
	logic miso_oe;
	logic miso_level;
	logic wake_host_out;
	logic wake_host_oe;
	logic wake_dev_out;
	logic wake_dev_oe;
	logic wake_level;

	assign miso_level = miso_oe ? miso : 1'b1;
	assign wake_level = (wake_host_oe ? wake_host_out : 1'b1) & (wake_dev_oe ? wake_dev_out : 1'b1);

	modport dev (input sclk, mosi, cs_n, wake_level,
		output miso, miso_oe, wake_dev_out, wake_dev_oe);
	modport host (output sclk, mosi, cs_n, wake_host_out, wake_host_oe,
		input miso_level, wake_level);
endinterface
`default_nettype wire

// *** hw/srpd_device.sv ***
/*
 SPI slave command interpreter: single-register write and read, power-down
 with a keyed sequence, wake-up on the wake pin, bit-order configuration.
 Assumes SPI mode 3 from a master no faster than a few hundred ns per half
 clock, and a register set that answers reg_rdata in the cycle of reg_rd.
*/
// Overview of operation
// (R1) Write: 0x20, address, data stores data
// (R2) One register per transaction, extra bytes ignored
// (R3) Register address never auto-increments
// (R4) Read: 0x21, address, dummy byte
// (R5) Addressed register returned on MISO
// (R6) Access happens once address is decoded
// (R7) Power-down: 0x30, 0x5A, 0xA5 in order
// (R8) Only exact sequence enters power-down
// (R9) Power-down stops oscillator, ignores SPI
// (R10) Host holds wake pin high beforehand
// (R11) Wake pin low leaves power-down
// (R12) Wake pin returns to GPIO after wake
// (R13) MSB first default; 0x42 LSB, 0x81 MSB
// (R14) Host always supplies SPI clock
// (R15) Chip select low starts, high ends transaction
`timescale 1ns/10ps
`default_nettype none
`include "srpd_map.svh"
module srpd_device
(
	input wire logic clk,
	input wire logic sys_rst,
	srpd_if.dev spi,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	output logic osc_stop,
	output logic wake_gpio_free,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic gpio_in
);
	import srpd_pkg::*;

	logic [2:0] sclk_s;
	logic [2:0] mosi_s;
	logic [2:0] cs_s;
	logic [2:0] wake_s;
	logic sclk_f;
	logic cs_f;
	logic wake_f;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic wake_low;
	logic active;
	logic byte_done;
	logic [2:0] bit_cnt;
	logic [7:0] rx;
	logic [7:0] next_rx;
	logic [7:0] tx_byte;
	logic [2:0] tx_idx;
	logic miso_q;
	logic lsb_first;
	logic pd;
	logic pd_armed;
	srpd_dev_state_t state;

	// Pin synchronisers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sclk_s <= 3'h7;
			mosi_s <= 3'h0;
			cs_s <= 3'h7;
			wake_s <= 3'h7;
		end
		else
		begin
			sclk_s <= {sclk_s[1:0], spi.sclk};
			mosi_s <= {mosi_s[1:0], spi.mosi};
			cs_s <= {cs_s[1:0], spi.cs_n};
			wake_s <= {wake_s[1:0], spi.wake_level};
		end
	end

	// Filtered levels change once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sclk_f <= 1'b1;
			cs_f <= 1'b1;
			wake_f <= 1'b1;
		end
		else
		begin
			if (sclk_s[1] == sclk_s[2])
				sclk_f <= sclk_s[2];
			if (cs_s[1] == cs_s[2])
				cs_f <= cs_s[2];
			if (wake_s[1] == wake_s[2])
				wake_f <= wake_s[2];
		end
	end

	// (R14) Clock edges come only from the master
	assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_f;
	assign sclk_fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_f;
	assign cs_fall = (cs_s[1] == cs_s[2]) && !cs_s[2] && cs_f;
	assign cs_rise = (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_f;
	assign wake_low = (wake_s[1] == wake_s[2]) && !wake_s[2];
	// (R9) Traffic ignored while powered down
	assign active = !cs_f && !pd;
	assign byte_done = sclk_rise && active && (bit_cnt == `SRPD_LAST_BIT);

	// (R13) Shift-in direction follows bit order
	always_comb
	begin
		if (lsb_first)
			next_rx = {mosi_s[2], rx[7:1]};
		else
			next_rx = {rx[6:0], mosi_s[2]};
	end

	// Bit counter and receive shifter
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bit_cnt <= 3'h0;
			rx <= 8'h00;
		end
		else if (cs_fall)
			bit_cnt <= 3'h0;
		else if (sclk_rise && active)
		begin
			bit_cnt <= bit_cnt + 3'h1;
			rx <= next_rx;
		end
	end

	// Command sequencer
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state <= ds_cmd;
		// (R15) Decoding restarts on each chip select
		else if (cs_fall)
			state <= ds_cmd;
		else if (pd && wake_low)
			state <= ds_ignore;
		else if (byte_done)
		begin
			case (state)
				ds_cmd:
				begin
					case (next_rx)
						`SRPD_CMD_REG_WR: state <= ds_wr_addr;
						`SRPD_CMD_REG_RD: state <= ds_rd_addr;
						`SRPD_CMD_PWR_DN: state <= ds_pd_key1;
						`SRPD_CMD_SPI_CFG: state <= ds_cfg;
						default: state <= ds_ignore;
					endcase
				end
				ds_wr_addr: state <= ds_wr_data;
				ds_rd_addr: state <= ds_rd_dummy;
				// (R8) Wrong key aborts the sequence
				ds_pd_key1: state <= (next_rx == `SRPD_KEY_FIRST) ? ds_pd_key2 : ds_ignore;
				// (R2) Further bytes reach no register
				default: state <= ds_ignore;
			endcase
		end
	end

	// Register address, write data and access strobes
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
		end
		else
		begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			if (byte_done)
			begin
				// (R3) Address taken as sent, never stepped
				if (state == ds_wr_addr || state == ds_rd_addr)
					reg_addr <= next_rx;
				// (R6) Read issued right after the address
				if (state == ds_rd_addr)
					reg_rd <= 1'b1;
				// (R1) Data byte stored to addressed register
				if (state == ds_wr_data)
				begin
					reg_wdata <= next_rx;
					reg_wr <= 1'b1;
				end
			end
		end
	end

	// (R5) Read data loaded for the dummy byte
	always_ff @(posedge clk)
	begin
		if (sys_rst || cs_fall)
			tx_byte <= 8'h00;
		else if (reg_rd)
			tx_byte <= reg_rdata;
		else if (byte_done)
			tx_byte <= 8'h00;
	end

	// (R13) Output bit index follows bit order
	assign tx_idx = lsb_first ? bit_cnt : (`SRPD_LAST_BIT - bit_cnt);

	// Mode 3 output: next bit driven on falling clock
	always_ff @(posedge clk)
	begin
		if (sys_rst || cs_fall)
			miso_q <= 1'b0;
		else if (sclk_fall && active)
			miso_q <= tx_byte[tx_idx];
	end

	// (R13) Bit-order configuration
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			lsb_first <= 1'b0;
		else if (byte_done && state == ds_cfg)
		begin
			if (next_rx == `SRPD_CFG_LSB_FIRST)
				lsb_first <= 1'b1;
			else if (next_rx == `SRPD_CFG_MSB_FIRST)
				lsb_first <= 1'b0;
		end
	end

	// (R7) Keys armed only as 0x30, 0x5A, 0xA5 and nothing more
	always_ff @(posedge clk)
	begin
		if (sys_rst || cs_fall)
			pd_armed <= 1'b0;
		else if (byte_done)
			pd_armed <= (state == ds_pd_key2) && (next_rx == `SRPD_KEY_SECOND);
	end

	// Power-down entry at frame end, exit on wake pin
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pd <= 1'b0;
		// (R11) Wake pin low restarts the oscillator
		else if (pd && wake_low)
			pd <= 1'b0;
		// (R8) Enter only on the complete key sequence
		else if (cs_rise && pd_armed)
			pd <= 1'b1;
	end

	// (R9) Oscillator stopped while powered down
	assign osc_stop = pd;
	// (R12) Pin handed back to GPIO out of power-down
	assign wake_gpio_free = !pd;
	assign spi.wake_dev_out = gpio_out;
	assign spi.wake_dev_oe = gpio_oe && !pd;
	assign gpio_in = wake_f;

	assign spi.miso = miso_q;
	assign spi.miso_oe = active;
endmodule
`default_nettype wire

// *** hw/srpd_host.sv ***
/*
 SPI master end: issues register write, register read, power-down,
 bit-order configuration and wake-up from a one-command user port.
 Assumes the device end of srpd_if on the same 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srpd_map.svh"
module srpd_host
(
	input wire logic clk,
	input wire logic sys_rst,
	srpd_if.host spi,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire srpd_pkg::srpd_op_t cmd_op,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [7:0] rsp_data
);
	import srpd_pkg::*;

	srpd_host_state_t state;
	srpd_op_t op;
	logic [7:0] frame [0:2];
	logic [1:0] last_byte;
	logic [1:0] byte_idx;
	logic [2:0] bit_idx;
	logic [11:0] cnt;
	logic [7:0] rx;
	logic [2:0] miso_s;
	logic lsb_first;
	logic sclk_q;
	logic mosi_q;
	logic cs_n_q;
	logic wake_out;
	logic wake_oe;
	logic [2:0] out_idx;

	assign cmd_ready = (state == hs_idle);
	assign out_idx = lsb_first ? bit_idx : (`SRPD_LAST_BIT - bit_idx);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			miso_s <= 3'h7;
		else
			miso_s <= {miso_s[1:0], spi.miso_level};
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= hs_idle;
			op <= op_write;
			cnt <= 12'h000;
			byte_idx <= 2'h0;
			bit_idx <= 3'h0;
			last_byte <= 2'h0;
			rx <= 8'h00;
			sclk_q <= 1'b1;
			mosi_q <= 1'b1;
			cs_n_q <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			lsb_first <= 1'b0;
			wake_out <= 1'b1;
			wake_oe <= 1'b0;
			frame[0] <= 8'h00;
			frame[1] <= 8'h00;
			frame[2] <= 8'h00;
		end
		else
		begin
			rsp_valid <= 1'b0;
			cnt <= cnt + 12'h001;
			case (state)
				hs_idle:
				begin
					cnt <= 12'h000;
					if (cmd_valid)
					begin
						op <= cmd_op;
						byte_idx <= 2'h0;
						bit_idx <= 3'h0;
						last_byte <= 2'h2;
						frame[1] <= cmd_addr;
						frame[2] <= cmd_data;
						case (cmd_op)
							op_write: frame[0] <= `SRPD_CMD_REG_WR;
							op_read: frame[0] <= `SRPD_CMD_REG_RD;
							op_power_down:
							begin
								frame[0] <= `SRPD_CMD_PWR_DN;
								frame[1] <= `SRPD_KEY_FIRST;
								frame[2] <= `SRPD_KEY_SECOND;
							end
							op_config:
							begin
								frame[0] <= `SRPD_CMD_SPI_CFG;
								frame[1] <= cmd_data;
								last_byte <= 2'h1;
							end
							default: frame[0] <= 8'h00;
						endcase
						// (R10) Wake pin held high before power-down
						if (cmd_op == op_power_down)
						begin
							wake_out <= 1'b1;
							wake_oe <= 1'b1;
						end
						if (cmd_op == op_wake)
						begin
							// (R11) Pull the wake pin low
							wake_out <= 1'b0;
							wake_oe <= 1'b1;
							state <= hs_wake;
						end
						else
						begin
							// (R15) Chip select opens the frame
							cs_n_q <= 1'b0;
							state <= hs_lead;
						end
					end
				end
				hs_lead:
				begin
					if (cnt == 12'(`SRPD_LEAD_CYC - 1))
					begin
						cnt <= 12'h000;
						sclk_q <= 1'b0;
						mosi_q <= frame[0][out_idx];
						state <= hs_low;
					end
				end
				hs_low:
				begin
					if (cnt == 12'(`SRPD_HALF_CYC - 1))
					begin
						// (R14) Host raises the clock and samples
						cnt <= 12'h000;
						sclk_q <= 1'b1;
						rx <= lsb_first ? {miso_s[2], rx[7:1]} : {rx[6:0], miso_s[2]};
						bit_idx <= bit_idx + 3'h1;
						state <= hs_high;
						if (bit_idx == `SRPD_LAST_BIT)
						begin
							byte_idx <= byte_idx + 2'h1;
							if (byte_idx == last_byte)
								state <= hs_lag;
						end
					end
				end
				hs_high:
				begin
					if (cnt == 12'(`SRPD_HALF_CYC - 1))
					begin
						cnt <= 12'h000;
						sclk_q <= 1'b0;
						mosi_q <= frame[byte_idx][out_idx];
						state <= hs_low;
					end
				end
				hs_lag:
				begin
					if (cnt == 12'(`SRPD_LAG_CYC - 1))
					begin
						cnt <= 12'h000;
						cs_n_q <= 1'b1;
						mosi_q <= 1'b1;
						state <= hs_gap;
						// (R4) Result taken after the dummy byte, as chip select rises
						if (op == op_read)
						begin
							rsp_valid <= 1'b1;
							rsp_data <= rx;
						end
						// (R13) Host follows the new bit order
						if (op == op_config && frame[1] == `SRPD_CFG_LSB_FIRST)
							lsb_first <= 1'b1;
						if (op == op_config && frame[1] == `SRPD_CFG_MSB_FIRST)
							lsb_first <= 1'b0;
					end
				end
				hs_gap:
				begin
					if (cnt == 12'(`SRPD_LAG_CYC - 1))
						state <= hs_idle;
				end
				hs_wake:
				begin
					if (cnt == 12'(`SRPD_WAKE_CYC - 1))
					begin
						// (R12) Pin released for GPIO use
						wake_oe <= 1'b0;
						wake_out <= 1'b1;
						state <= hs_idle;
					end
				end
				default: state <= hs_idle;
			endcase
		end
	end

	assign spi.sclk = sclk_q;
	assign spi.mosi = mosi_q;
	assign spi.cs_n = cs_n_q;
	assign spi.wake_host_out = wake_out;
	assign spi.wake_host_oe = wake_oe;
endmodule
`default_nettype wire

// *** verif/srpd_chk.sv ***
/*
 Concurrent checks on the link between the SPI master and the interpreter.
 Assumes one clock domain and instantiation beside the srpd_if instance.
*/
`timescale 1ns/10ps
`default_nettype none
module srpd_chk
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic miso_oe,
	input wire logic wake_dev_oe,
	input wire logic wake_level,
	input wire logic osc_stop,
	input wire logic reg_wr,
	input wire logic reg_rd
);
	logic cs_q;
	logic [1:0] acc_cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cs_q <= 1'b1;
			acc_cnt <= 2'h0;
		end
		else
		begin
			cs_q <= cs_n;
			if (cs_q && !cs_n)
				acc_cnt <= 2'h0;
			else if ((reg_wr || reg_rd) && acc_cnt != 2'h2)
				acc_cnt <= acc_cnt + 2'h1;
		end
	end

	sequence s_wake_pull;
		osc_stop && $fell(wake_level);
	endsequence

	sequence s_idle_cs;
		cs_n [*5];
	endsequence

	a_one_access: assert property (acc_cnt != 2'h2)
		else $error("two register accesses in one frame");
	a_idle_miso: assert property (s_idle_cs |-> !miso_oe)
		else $error("miso driven while deselected");
	a_pd_miso_off: assert property (osc_stop |-> !miso_oe)
		else $error("miso driven in power-down");
	a_pd_no_access: assert property (osc_stop |-> !(reg_wr || reg_rd))
		else $error("register access in power-down");
	a_pd_at_end: assert property ($rose(osc_stop) |-> cs_n)
		else $error("power-down entered inside a frame");
	a_wake_exit: assert property (s_wake_pull |-> ##[1:8] !osc_stop)
		else $error("no wake after pin pulled low");
	a_pd_pin_free: assert property (osc_stop |-> !wake_dev_oe)
		else $error("wake pin driven in power-down");
	a_access_in_frame: assert property ((reg_wr || reg_rd) |-> !cs_n)
		else $error("access delayed past end of frame");
	a_sclk_idle: assert property (cs_n |-> sclk && mosi)
		else $error("clock or data not idle while deselected");
	a_wake_high_pd: assert property ($rose(osc_stop) |-> wake_level)
		else $error("wake pin low at power-down entry");
endmodule
`default_nettype wire

// *** verif/spi_register_and_powerdown_cmds_tb.sv ***
/*
 Self-checking bench joining master and interpreter through srpd_if.
 Assumes the bench models the register set behind the interpreter.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_register_and_powerdown_cmds_tb;
	import srpd_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_ready, rsp_valid, osc_stop, wake_gpio_free, gpio_in, reg_wr, reg_rd, sclk_q;
	srpd_op_t cmd_op = op_write;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic gpio_out = 1'b1;
	logic gpio_oe = 1'b0;
	logic [7:0] rsp_data, reg_addr, reg_wdata, reg_rdata, rd_cnt, wr_cnt, rd_addr;
	logic [7:0] regs [256];
	logic [23:0] wire_sr;
	int checks = 0;
	int n_mismatch = 0;
	int cyc = 0;

	srpd_if link();
	srpd_device srpd_device_inst (.clk(clk), .sys_rst(sys_rst), .spi(link),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .osc_stop(osc_stop), .wake_gpio_free(wake_gpio_free),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));
	srpd_host srpd_host_inst (.clk(clk), .sys_rst(sys_rst), .spi(link),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
	srpd_chk srpd_chk_inst (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
		.mosi(link.mosi), .cs_n(link.cs_n), .miso_oe(link.miso_oe),
		.wake_dev_oe(link.wake_dev_oe), .wake_level(link.wake_level),
		.osc_stop(osc_stop), .reg_wr(reg_wr), .reg_rd(reg_rd));

	assign reg_rdata = regs[reg_addr];

	initial
	begin
		forever #5 clk = ~clk;
	end

	// Register set, access counts and wire capture of master data
	always @(posedge clk)
	begin
		sclk_q <= link.sclk;
		if (!link.cs_n && link.sclk && !sclk_q)
			wire_sr <= {wire_sr[22:0], link.mosi};
		if (sys_rst)
		begin
			rd_cnt <= 8'h00;
			wr_cnt <= 8'h00;
		end
		if (reg_wr)
		begin
			regs[reg_addr] <= reg_wdata;
			wr_cnt <= wr_cnt + 8'h01;
		end
		if (reg_rd)
		begin
			rd_cnt <= rd_cnt + 8'h01;
			rd_addr <= reg_addr;
		end
		cyc++;
		if (cyc == 50000)
		begin
			n_mismatch++;
			summarize();
		end
	end

	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev[i] = b[7 - i];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic issue(input srpd_op_t op, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
	endtask

	task automatic t_write_read();
		issue(op_write, 8'h11, 8'h3c);
		issue(op_write, 8'h12, 8'hc5);
		check(regs[8'h11], 8'h3c);
		check(regs[8'h12], 8'hc5);
		check(wr_cnt, 8'h02);
		issue(op_read, 8'h11, 8'h77);
		check(rsp_data, 8'h3c);
		check(rd_addr, 8'h11);
		check(rd_cnt, 8'h01);
	endtask

	task automatic t_power();
		issue(op_power_down, 8'h00, 8'h00);
		check({7'h00, osc_stop}, 8'h01);
		@(posedge clk);
		gpio_out <= 1'b0;
		gpio_oe <= 1'b1;
		repeat (8) @(negedge clk);
		check({7'h00, link.wake_level}, 8'h01);
		check({7'h00, osc_stop}, 8'h01);
		issue(op_read, 8'h11, 8'h00);
		check(rsp_data, 8'hff);
		check(rd_cnt, 8'h01);
		issue(op_wake, 8'h00, 8'h00);
		check({7'h00, osc_stop}, 8'h00);
		check({7'h00, wake_gpio_free}, 8'h01);
		check({7'h00, gpio_in}, 8'h00);
		@(posedge clk);
		gpio_oe <= 1'b0;
		gpio_out <= 1'b1;
		repeat (8) @(negedge clk);
		check({7'h00, gpio_in}, 8'h01);
		issue(op_read, 8'h12, 8'h00);
		check(rsp_data, 8'hc5);
	endtask

	task automatic t_order();
		issue(op_config, 8'h00, 8'h42);
		issue(op_write, 8'h12, 8'h01);
		check(wire_sr[23:16], rev(8'h20));
		check(wire_sr[15:8], rev(8'h12));
		check(wire_sr[7:0], rev(8'h01));
		check(regs[8'h12], 8'h01);
		issue(op_config, 8'h00, 8'h81);
		issue(op_write, 8'h11, 8'h5a);
		check(wire_sr[23:16], 8'h20);
		check(wire_sr[7:0], 8'h5a);
		check(regs[8'h11], 8'h5a);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_write_read();
		t_power();
		t_order();
		summarize();
	end
endmodule
`default_nettype wire
